// File: dv/dcf_fifo_flags_properties.sv
// concurrent checks on the ports of the fifo flag block
module dcf_fifo_flags_chk
	import dcf_pkg::*;
#(
	parameter int WIDTH = 9
) (
	// clock and reset
	input wire logic             clk_sys,
	input wire logic             rstn,
	// apb and pins
	input wire logic [7:0]       paddr,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [31:0]      pwdata,
	input wire logic             master_reset_n,
	input wire logic             partial_reset_n,
	// stream
	input wire logic             wr_en,
	input wire logic             rd_en,
	input wire logic [WIDTH-1:0] read_data_out,
	input wire dcf_flags_type    flags
);
	timeunit 1ns;
	timeprecision 100ps;
	// flags resettle after a pin reset, so the checks rest for a while
	logic [2:0] quiet_q;
	wire        pins_ok = rstn && master_reset_n && partial_reset_n;
	wire        retx_wr = psel && penable && pwrite && paddr == DCF_ADDR_CTRL
		&& pwdata[CTRL_RETX_BIT];
	always_ff @(posedge clk_sys) begin
		if (!pins_ok) begin
			quiet_q <= 3'h0;
		end else if (quiet_q != 3'h7) begin
			quiet_q <= quiet_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn || quiet_q != 3'h7);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_std_setup;
		(!flags.empty_flag_n) [*7] ##1 flags.empty_flag_n;
	endsequence
	sequence s_fall_setup;
		flags.output_ready_n [*8] ##1 !flags.output_ready_n;
	endsequence
	property p_retx_std;
		retx_wr && flags.empty_flag_n && flags.output_ready_n |-> ##3 s_std_setup;
	endproperty
	property p_retx_fall;
		retx_wr && !flags.output_ready_n |-> ##3 s_fall_setup;
	endproperty
	property p_empty_rise;
		$rose(flags.empty_flag_n) |-> $past(wr_en, 2) || $past(retx_wr, 10);
	endproperty
	property p_orn_fall;
		$fell(flags.output_ready_n) |-> $past(wr_en, 3) || $past(retx_wr, 11);
	endproperty
	property p_half_fall;
		// a replay moves the read pointer back, which also raises the level
		$fell(flags.half_full_flag_n) |-> $past(wr_en) || $past(retx_wr);
	endproperty
	property p_half_rise;
		$rose(flags.half_full_flag_n) |-> $past(rd_en);
	endproperty
	property p_ae_rise;
		$rose(flags.almost_empty_flag_n) |-> $past(wr_en, 2) || $past(retx_wr, 2);
	endproperty
	property p_full_rise;
		$rose(flags.full_flag_n) |-> $past(rd_en, 2);
	endproperty
	property p_rd_hold;
		rd_en && !flags.empty_flag_n |=> $stable(read_data_out);
	endproperty
	a_retx_std: assert property (p_retx_std) else $error("empty flag setup time wrong");
	a_retx_fall: assert property (p_retx_fall) else $error("ready setup time wrong");
	a_empty_rise: assert property (p_empty_rise) else $error("empty flag rose late");
	a_orn_fall: assert property (p_orn_fall) else $error("output ready fell late");
	a_half_fall: assert property (p_half_fall) else $error("half flag fell off a write");
	a_half_rise: assert property (p_half_rise) else $error("half flag rose off a read");
	a_ae_rise: assert property (p_ae_rise) else $error("almost empty rose late");
	a_full_rise: assert property (p_full_rise) else $error("full flag rose late");
	a_rd_hold: assert property (p_rd_hold) else $error("read while empty moved data");
endmodule

bind dcf_fifo_flags dcf_fifo_flags_chk #(.WIDTH(WIDTH)) chk_u (
	.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .master_reset_n(master_reset_n),
	.partial_reset_n(partial_reset_n), .wr_en(wr_en), .rd_en(rd_en),
	.read_data_out(read_data_out), .flags(flags)
);

// File: dv/dcf_stream_partner.sv
// producer and consumer model for the fifo stream ports
module dcf_stream_partner
	import dcf_pkg::*;
#(
	parameter int WIDTH = 9
) (
	// clock and flags
	input wire logic           clk_sys,
	input wire dcf_flags_type  flags,
	// stream
	output logic               wr_en,
	output logic [WIDTH-1:0]   wr_data,
	output logic               rd_en
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0]      lfsr_q = 32'h0000_bc65;
	logic [WIDTH-1:0] exp_q[$];
	logic [WIDTH-1:0] hist[$];
	int               waits_lost = 0;
	initial begin
		wr_en = 1'b0;
		wr_data = '0;
		rd_en = 1'b0;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// each word is noted for the monitor as it is launched
	task automatic put(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			lfsr_q = lfsr_next(lfsr_q);
			wr_en <= 1'b1;
			wr_data <= lfsr_q[WIDTH-1:0];
			exp_q.push_back(lfsr_q[WIDTH-1:0]);
			hist.push_back(lfsr_q[WIDTH-1:0]);
		end
		@(posedge clk_sys);
		wr_en <= 1'b0;
		// a released bus must not look like the last word
		wr_data <= ~wr_data;
	endtask
	// with hold_off set, reads start once the flag shows data, setup included; with it clear they start at once
	task automatic take(input int n, input bit fall, input bit hold_off);
		int t;
		t = 0;
		@(posedge clk_sys);
		while (hold_off && t < 200 && (fall ? flags.output_ready_n !== 1'b0 :
				flags.empty_flag_n !== 1'b1)) begin
			@(posedge clk_sys);
			t++;
		end
		if (t == 200) begin
			waits_lost++;
		end
		rd_en <= 1'b1;
		repeat (n) @(posedge clk_sys);
		rd_en <= 1'b0;
	endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the fifo flag block
module tb_top
	import dcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEPTH = 256;
	// serial offsets: X bits each, empty offset first, lsb first
	localparam int SER_X   = $clog2(DEPTH) - 1;
	localparam int SER_AE  = 5;
	localparam int SER_AF  = 9;
	localparam int SER_VAL = (SER_AF << SER_X) | SER_AE;
	logic          clk_sys = 1'b0;
	logic          rstn = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [31:0]   pwdata = 32'h0000_0000;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic          master_reset_n = 1'b1;
	logic          partial_reset_n = 1'b1;
	logic          offset_load_n = 1'b0;
	logic          wr_en;
	logic          rd_en;
	logic [8:0]    wr_data;
	logic [8:0]    read_data_out;
	dcf_flags_type flags;
	logic [31:0]   rd_q;
	logic          err_q;
	bit            pend = 1'b0;
	bit            fw = 1'b0;
	int            fails = 0;
	int            compares = 0;

	always #4 clk_sys = ~clk_sys;

	dcf_fifo_flags #(.DEPTH(DEPTH), .WIDTH(9)) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_reset_n(master_reset_n),
		.partial_reset_n(partial_reset_n), .offset_load_n(offset_load_n),
		.wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
		.read_data_out(read_data_out), .flags(flags)
	);
	dcf_stream_partner #(.WIDTH(9)) partner_u (
		.clk_sys(clk_sys), .flags(flags), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en)
	);
	// ----------------------------------------------------------------
	// compares and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [8:0] got);
		logic [8:0] exp;
		exp = partner_u.exp_q.size() > 0 ? partner_u.exp_q.pop_front() : 'z;
		chk_reg({23'h0, got}, {23'h0, exp});
	endtask
	// a standard read shows its word after the taking edge
	always @(posedge clk_sys) begin
		if (pend) begin
			chk_word(read_data_out);
		end
		if (fw && rd_en && flags.output_ready_n === 1'b0) begin
			chk_word(read_data_out);
		end
		pend = !fw && rd_en && flags.empty_flag_n === 1'b1;
	end
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			t++;
		end while (pready !== 1'b1 && t < 50);
		rd_q = prdata;
		err_q = pslverr;
		fails += (t == 50);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic flag_is(input int b, input logic e);
		settle();
		chk_reg({31'h0, flags[b]}, {31'h0, e});
	endtask
	task automatic pulse(input bit m);
		partner_u.exp_q.delete();
		partner_u.hist.delete();
		@(posedge clk_sys);
		master_reset_n <= !m;
		partial_reset_n <= m;
		repeat (4) @(posedge clk_sys);
		master_reset_n <= 1'b1;
		partial_reset_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
	endtask
	// the thresholds sit one word higher in fall-through mode
	task automatic fill();
		apb(1'b1, DCF_ADDR_EMPTY_OFS, 32'h0000_0003);
		partner_u.put(3 + fw);
		flag_is(2, 1'b0);
		partner_u.put(1);
		flag_is(2, 1'b1);
		partner_u.put(DEPTH / 2 - 4);
		flag_is(0, 1'b1);
		partner_u.put(1);
		flag_is(0, 1'b0);
		apb(1'b0, DCF_ADDR_LEVEL, 32'h0000_0000);
		chk_reg(rd_q, 32'(DEPTH / 2 + 1 + fw));
	endtask
	task automatic stop_test();
		fails += partner_u.waits_lost;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		stop_test();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		apb(1'b1, DCF_ADDR_CTRL, 32'h0000_0000);
		pulse(1'b1);
		settle();
		chk_reg({25'h0, flags}, 32'h0000_003b);
		apb(1'b0, DCF_ADDR_EMPTY_OFS, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_007f);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk_reg({rd_q[30:0], err_q}, 32'h0000_0001);
		fill();
		partner_u.take(2, 1'b0, 1'b1);
		// replay stays under the depth-2 limit on the writer
		apb(1'b1, DCF_ADDR_CTRL, 32'h0000_0002);
		partner_u.exp_q = partner_u.hist;
		// the empty flag falls a cycle after the request, so look past it
		repeat (2) @(posedge clk_sys);
		partner_u.take(DEPTH / 2 + 1, 1'b0, 1'b1);
		flag_is(0, 1'b1);
		partner_u.take(1, 1'b0, 1'b0);
		settle();
		chk_reg({23'h0, read_data_out}, {23'h0, partner_u.hist[DEPTH / 2]});
		pulse(1'b0);
		partner_u.put(DEPTH);
		flag_is(5, 1'b0);
		partner_u.take(1, 1'b0, 1'b1);
		flag_is(5, 1'b1);
		partner_u.take(DEPTH - 1, 1'b0, 1'b1);
		apb(1'b1, DCF_ADDR_CTRL, 32'h0000_0001);
		fw = 1'b1;
		pulse(1'b1);
		settle();
		chk_reg({25'h0, flags}, 32'h0000_0073);
		fill();
		apb(1'b1, DCF_ADDR_CTRL, 32'h0000_0003);
		partner_u.exp_q = partner_u.hist;
		partner_u.take(3, 1'b1, 1'b1);
		settle();
		// serial offset load, parallel writes refused meanwhile
		offset_load_n <= 1'b1;
		pulse(1'b1);
		for (int i = 0; i < 2 * SER_X; i++) begin
			apb(1'b1, DCF_ADDR_SERIAL_IN, 32'((SER_VAL >> i) & 1));
		end
		apb(1'b1, DCF_ADDR_EMPTY_OFS, 32'h0000_0033);
		apb(1'b0, DCF_ADDR_EMPTY_OFS, 32'h0000_0000);
		chk_reg(rd_q, 32'(SER_AE));
		apb(1'b0, DCF_ADDR_FULL_OFS, 32'h0000_0000);
		chk_reg(rd_q, 32'(SER_AF));
		apb(1'b0, DCF_ADDR_STATUS, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_0373);
		// fall-through fills one word beyond the memory depth
		partner_u.put(DEPTH + 1);
		flag_is(3, 1'b1);
		flag_is(1, 1'b0);
		partner_u.take(1, 1'b1, 1'b1);
		flag_is(3, 1'b0);
		stop_test();
	end
endmodule

// File: hw/dcf_fifo_flags.sv
// single-clock model of a dual-port 9-bit fifo with its status flags and apb registers
//
// The placing of the registers and the APB register port are this design's own decisions.

module dcf_fifo_flags
	import dcf_pkg::*;
#(
	parameter int DEPTH = 16384,
	parameter int WIDTH = 9
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	// apb slave
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// device pins
	input  wire logic               master_reset_n,
	input  wire logic               partial_reset_n,
	input  wire logic               offset_load_n,
	// write side
	input  wire logic               wr_en,
	input  wire logic [WIDTH-1:0]   wr_data,
	// read side
	input  wire logic               rd_en,
	output logic      [WIDTH-1:0]   read_data_out,
	output dcf_flags_type           flags
);

	// ----------------------------------------------------------------
	// derived sizes
	// ----------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int OW = AW - 1;
	localparam int CW = AW + 2;
	localparam int SW = 2 * OW;
	localparam logic [CW-1:0] D_STD     = CW'(DEPTH);
	localparam logic [CW-1:0] D_FIRST_WORD_FALL_THROUGH    = CW'(DEPTH + 1);
	localparam logic [CW-1:0] HALF_STD  = CW'(DEPTH / 2);
	localparam logic [CW-1:0] HALF_FIRST_WORD_FALL_THROUGH = CW'(DEPTH / 2 + 1);
	localparam logic [OW-1:0] OFS_LO    = OW'(OFS_DEFAULT_LO);
	localparam logic [OW-1:0] OFS_HI    = OW'(OFS_DEFAULT_HI);
	localparam logic [3:0]    RT_LOAD   = 4'(RETX_CYC);
	localparam logic [4:0]    SER_LAST  = 5'(SW - 1);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pin_s1_q <= 3'h7;
			pin_s2_q <= 3'h7;
		end else begin
			pin_s1_q <= {offset_load_n, partial_reset_n, master_reset_n};
			pin_s2_q <= pin_s1_q;
		end
	end

	wire mrs_act = !pin_s2_q[0];
	wire prs_act = !pin_s2_q[1];
	wire ld_lvl  = pin_s2_q[2];
	wire clr     = mrs_act | prs_act;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_q;
	logic [AW:0]      rptr_q;
	logic             ov_q;
	logic             ne_d1_q;
	logic [3:0]       rt_cnt_q;
	logic             mode_q;
	logic             ctrl_first_word_fall_through_q;
	logic             serial_mode_q;
	logic [OW-1:0]    ae_ofs_q;
	logic [OW-1:0]    af_ofs_q;
	logic [SW-1:0]    ser_sh_q;
	logic [4:0]       ser_cnt_q;
	logic [WIDTH-1:0] dout_q;
	logic [31:0]      prdata_q;
	dcf_flags_type    flags_q;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire acc      = psel & penable;
	wire setup    = psel & !penable;
	wire hit_ctrl = paddr == DCF_ADDR_CTRL;
	wire hit_ae   = paddr == DCF_ADDR_EMPTY_OFS;
	wire hit_af   = paddr == DCF_ADDR_FULL_OFS;
	wire hit_ser  = paddr == DCF_ADDR_SERIAL_IN;
	wire hit_stat = paddr == DCF_ADDR_STATUS;
	wire hit_lvl  = paddr == DCF_ADDR_LEVEL;
	wire hit_any  = hit_ctrl | hit_ae | hit_af | hit_ser | hit_stat | hit_lvl;
	wire wr_acc   = acc & pwrite & hit_any;
	wire wr_ctrl  = wr_acc & hit_ctrl;
	wire par_ok   = !serial_mode_q & !mrs_act;
	wire wr_ae    = wr_acc & hit_ae & par_ok;
	wire wr_af    = wr_acc & hit_af & par_ok;
	wire wr_ser   = wr_acc & hit_ser & serial_mode_q & !mrs_act;

	// ----------------------------------------------------------------
	// counts and transfer conditions
	// ----------------------------------------------------------------
	wire [AW:0]   ram_cnt  = wptr_q - rptr_q;
	wire [CW-1:0] tot      = CW'(ram_cnt) + CW'(ov_q);
	wire          ram_ne   = ram_cnt != '0;
	wire          rt_busy  = rt_cnt_q != 4'h0;
	wire          rt_start = wr_ctrl & pwdata[CTRL_RETX_BIT] & !clr;
	wire          wr_ok    = wr_en & (CW'(ram_cnt) != D_STD) & !clr;
	// reads are refused while retransmit setup runs, so an early reader gets nothing
	wire rd_std  = !mode_q & rd_en & flags_q.empty_flag_n & ram_ne & !rt_busy;
	wire consume = mode_q & rd_en & ov_q & !rt_busy;
	wire load    = mode_q & ram_ne & ne_d1_q & (!ov_q | consume) & !rt_busy;
	wire pop     = rd_std | load;

	// ----------------------------------------------------------------
	// next pointers
	// ----------------------------------------------------------------
	wire [AW:0] wptr_d = clr ? '0 : wptr_q + (AW+1)'(wr_ok);
	wire [AW:0] rptr_d = (clr | rt_start) ? '0 : rptr_q + (AW+1)'(pop);
	wire        ov_d   = (clr | rt_start) ? 1'b0 : (load ? 1'b1 : (consume ? 1'b0 : ov_q));
	wire [AW:0] cnt_d  = wptr_d - rptr_d;
	wire [CW-1:0] tot_d = CW'(cnt_d) + CW'(ov_d);

	// ----------------------------------------------------------------
	// flag equations
	// ----------------------------------------------------------------
	wire [CW-1:0] ae_thr = mode_q ? CW'(ae_ofs_q) + CW'(1) : CW'(ae_ofs_q);
	wire [CW-1:0] af_thr = (mode_q ? D_FIRST_WORD_FALL_THROUGH : D_STD) - CW'(af_ofs_q);
	wire [CW-1:0] hf_thr = mode_q ? HALF_FIRST_WORD_FALL_THROUGH : HALF_STD;
	wire [CW-1:0] lvl    = mode_q ? tot : CW'(ram_cnt);
	dcf_flags_type flags_d;

	// unused function of each dual pin rests at its inactive high level
	assign flags_d.empty_flag_n        = mode_q | (ram_ne & !rt_busy);
	assign flags_d.output_ready_n      = !mode_q | !ov_d;
	assign flags_d.full_flag_n         = mode_q | (CW'(ram_cnt) != D_STD);
	assign flags_d.input_ready_n       = !mode_q | (tot == D_FIRST_WORD_FALL_THROUGH);
	assign flags_d.almost_empty_flag_n = lvl > ae_thr;
	assign flags_d.almost_full_flag_n  = lvl < af_thr;
	// half-full uses next-state count so it moves on the very edge of the transfer
	assign flags_d.half_full_flag_n    = !((mode_q ? tot_d : CW'(cnt_d)) > hf_thr);

	// ----------------------------------------------------------------
	// serial offset shift
	// ----------------------------------------------------------------
	wire [SW-1:0] ser_nx   = {pwdata[SER_DATA_BIT], ser_sh_q[SW-1:1]};
	wire          ser_done = wr_ser & (ser_cnt_q == SER_LAST);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire [31:0] stat_word = (32'(flags_q) << STAT_FLAGS_LSB)
		| (32'(mode_q) << STAT_MODE_BIT)
		| (32'(serial_mode_q) << STAT_SERIAL_BIT)
		| (32'(rt_busy) << STAT_RTBUSY_BIT);
	wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_first_word_fall_through_q) << CTRL_FIRST_WORD_FALL_THROUGH_BIT :
		hit_ae   ? 32'(ae_ofs_q) :
		hit_af   ? 32'(af_ofs_q) :
		hit_stat ? stat_word :
		hit_lvl  ? 32'(lvl) : 32'h0000_0000;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (wr_ok) begin
			mem[wptr_q[AW-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dout_q <= '0;
		end else if (pop) begin
			dout_q <= mem[rptr_q[AW-1:0]];
		end
	end

	// ----------------------------------------------------------------
	// pointers, fall-through stage, retransmit timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			ov_q    <= 1'b0;
			ne_d1_q <= 1'b0;
		end else begin
			wptr_q  <= wptr_d;
			rptr_q  <= rptr_d;
			ov_q    <= ov_d;
			// extra stage gives the two-cycle fall-through latency
			ne_d1_q <= ram_ne & !rt_busy & !clr;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn || clr) begin
			rt_cnt_q <= 4'h0;
		end else if (rt_start) begin
			rt_cnt_q <= RT_LOAD;
		end else if (rt_busy) begin
			rt_cnt_q <= rt_cnt_q - 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			flags_q <= '1;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------------------------------
	// configuration, mode and offsets
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctrl_first_word_fall_through_q <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_first_word_fall_through_q <= pwdata[CTRL_FIRST_WORD_FALL_THROUGH_BIT];
		end
	end

	// mode and offset defaults are taken while master reset is held
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mode_q        <= 1'b0;
			serial_mode_q <= 1'b0;
			ae_ofs_q      <= OFS_LO;
			af_ofs_q      <= OFS_LO;
		end else if (mrs_act) begin
			mode_q        <= ctrl_first_word_fall_through_q;
			serial_mode_q <= ld_lvl;
			ae_ofs_q      <= ld_lvl ? OFS_HI : OFS_LO;
			af_ofs_q      <= ld_lvl ? OFS_HI : OFS_LO;
		end else if (ser_done) begin
			ae_ofs_q <= ser_nx[OW-1:0];
			af_ofs_q <= ser_nx[SW-1:OW];
		end else begin
			if (wr_ae) begin
				ae_ofs_q <= pwdata[OW-1:0];
			end
			if (wr_af) begin
				af_ofs_q <= pwdata[OW-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn || mrs_act) begin
			ser_sh_q  <= '0;
			ser_cnt_q <= 5'h00;
		end else if (wr_ser) begin
			ser_sh_q  <= ser_nx;
			ser_cnt_q <= ser_done ? 5'h00 : ser_cnt_q + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// apb read data
	// ----------------------------------------------------------------
	// captured in the setup cycle so the access cycle answers with no wait
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata        = prdata_q;
	assign pready        = acc;
	assign pslverr       = acc & !hit_any;
	assign read_data_out = dout_q;
	assign flags         = flags_q;

endmodule

// File: hw/dcf_pkg.sv
// constants, register map and flag carrier of the single-clock fifo flag block
package dcf_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] DCF_ADDR_CTRL      = 8'h00;
	localparam logic [7:0] DCF_ADDR_EMPTY_OFS = 8'h04;
	localparam logic [7:0] DCF_ADDR_FULL_OFS  = 8'h08;
	localparam logic [7:0] DCF_ADDR_SERIAL_IN = 8'h0c;
	localparam logic [7:0] DCF_ADDR_STATUS    = 8'h10;
	localparam logic [7:0] DCF_ADDR_LEVEL     = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_FIRST_WORD_FALL_THROUGH_BIT   = 0;
	localparam int CTRL_RETX_BIT   = 1;
	localparam int SER_DATA_BIT    = 0;
	localparam int STAT_FLAGS_LSB  = 0;
	localparam int STAT_MODE_BIT   = 8;
	localparam int STAT_SERIAL_BIT = 9;
	localparam int STAT_RTBUSY_BIT = 10;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam int OFS_DEFAULT_LO = 127;
	localparam int OFS_DEFAULT_HI = 1023;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int RETX_NS       = 60;
	localparam int RETX_CYC      = (RETX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// flag carrier, all active low
	// ----------------------------------------------------------------
	typedef struct packed {
		logic empty_flag_n;
		logic full_flag_n;
		logic output_ready_n;
		logic input_ready_n;
		logic almost_empty_flag_n;
		logic almost_full_flag_n;
		logic half_full_flag_n;
	} dcf_flags_type;

	localparam int FLAGS_W = $bits(dcf_flags_type);

endpackage
